// ==== shared/ocs_defs.svh ====
// constants of the clock source select and switch block
// assumes inclusion by the logic files and the testbench, before the package import
`ifndef OCS_DEFS_SVH
`define OCS_DEFS_SVH

// ============================================================
// source select encodings
`define OCS_SEL_INT          2'h0
`define OCS_SEL_EXT          2'h1
`define OCS_SEL_RC           2'h2
`define OCS_SEL_XTAL         2'h3

// ============================================================
// trim reset value and width
`define OCS_TRIM_RESET       8'h80
`define OCS_TRIM_WIDTH       8

// ============================================================
// timing
// rising edges of the external clock that prove it is alive
`define OCS_ACTIVITY_EDGES   2'h2
// nominal internal oscillator frequency, trimmed by the analog cell
`define OCS_INT_FREQ_KHZ     4000
// system clock period, 20 MHz
`define OCS_SYS_PERIOD_NS    50

`endif

// ==== shared/ocs_pkg.sv ====
// types shared by the clock source select and switch block
// assumes nothing of its surroundings beyond a SystemVerilog compiler
package ocs_pkg;

	// ============================================================
	// configuration word carried into the block
	typedef struct packed {
		logic [1:0] srcSel;   // oscillator source select
		logic       pinOutEn; // clock pin output enable for the second pin, in internal and rc modes only
	} ocs_cfg_type;

	// ============================================================
	// one tri-state pin as data plus enable
	typedef struct packed {
		logic out;
		logic oe;
	} ocs_pin_type;

	// ============================================================
	// handover sequencer, one-hot
	typedef enum logic [4:0] {
		ST_INT    = 5'b00001, // running on internal oscillator
		ST_CHECK  = 5'b00010, // counting external rising edges
		ST_ALIGN  = 5'b00100, // waiting for both clocks low
		ST_ENGAGE = 5'b01000, // external drives, status set
		ST_EXT    = 5'b10000  // internal stopped, final
	} ocs_state_type;

endpackage

// ==== logic/ocs_edge_check.sv ====
// activity checker for the chosen external clock
// assumes the clock input is asynchronous to clk_sys and much slower than it
`timescale 1ns/1ps
`include "ocs_defs.svh"

module ocs_edge_check
	import ocs_pkg::*;
(
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// control and clock under test
	input  wire logic arm,
	input  wire logic clkIn,
	// results
	output logic      level,
	output logic      seen
);

	// ============================================================
	// state
	logic       syncFirst;
	logic       syncPrev;
	logic [1:0] edgeCount;
	logic       next_syncFirst;
	logic       next_level;
	logic       next_syncPrev;
	logic [1:0] next_edgeCount;
	logic       next_seen;

	// two-stage synchroniser, then edge detection on the second stage only
	always_comb begin
		next_syncFirst = clkIn;
		next_level     = syncFirst;
		next_syncPrev  = level;
		next_edgeCount = edgeCount;
		next_seen      = seen;
		if (!arm) begin
			next_edgeCount = 2'h0;
			next_seen      = 1'b0;
		end else if (level && !syncPrev && edgeCount != `OCS_ACTIVITY_EDGES) begin
			next_edgeCount = edgeCount + 2'h1;
			next_seen      = (edgeCount + 2'h1) == `OCS_ACTIVITY_EDGES;
		end
	end

	// registers only
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			syncFirst <= 1'b0;
			level     <= 1'b0;
			syncPrev  <= 1'b0;
			edgeCount <= 2'h0;
			seen      <= 1'b0;
		end else begin
			syncFirst <= next_syncFirst;
			level     <= next_level;
			syncPrev  <= next_syncPrev;
			edgeCount <= next_edgeCount;
			seen      <= next_seen;
		end
	end

	// ============================================================
	// checks
	seen_needs_edges_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		seen |-> edgeCount == `OCS_ACTIVITY_EDGES)
		else $error("activity flag set before two rising edges");

endmodule // ocs_edge_check

// ==== logic/ocs_source_switch.sv ====
// clock source selection, glitch-free internal to external handover,
// clock pin function mux and quad/double rate clock generation
// assumes all clock sources and pins are sampled as ordinary inputs of clk_sys,
// and that the system integration module drops the run enable in stop mode
`timescale 1ns/1ps
`include "ocs_defs.svh"

module ocs_source_switch
	import ocs_pkg::*;
(
	// clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        rst_n,
	// configuration and software control
	input  wire ocs_cfg_type                 cfg,
	input  wire logic                        ctrlWrite,
	input  wire logic                        ctrlWriteEnable,
	input  wire logic                        trimWrite,
	input  wire logic [`OCS_TRIM_WIDTH-1:0]  trimWriteData,
	// clock sources, sampled
	input  wire logic                        intSourceClock,
	input  wire logic                        rcSourceClock,
	input  wire logic                        crystalClock,
	input  wire logic                        clockInputPin,
	input  wire logic                        oscillatorRunEnable,
	// port a bit four path and second clock pin
	input  wire ocs_pin_type                 portABit4,
	input  wire logic                        secondPinIn,
	// clocks to the system integration module
	output logic                             quadRateClock,
	output logic                             doubleRateClock,
	// status and control readback
	output logic                             extClockGenEnable,
	output logic                             extClockEngaged,
	// oscillator cell controls
	output logic                             intOscRun,
	output logic                             extOscRun,
	output logic [`OCS_TRIM_WIDTH-1:0]       intFreqTrim,
	output logic                             clockInputIsClock,
	// second clock pin drive and port read path
	output logic                             secondPinOut,
	output logic                             secondPinOe,
	output logic                             portABit4In
);

	// ============================================================
	// decode helpers

	// true for the sources that have an on-chip oscillator cell
	function automatic logic ocs_has_cell(input logic [1:0] sel);
		ocs_has_cell = (sel == `OCS_SEL_RC) || (sel == `OCS_SEL_XTAL);
	endfunction

	// picks the raw external clock named by a select code
	function automatic logic ocs_pick_clock(input logic [1:0] sel,
		input logic pin, input logic rc, input logic xtal);
		case (sel)
			`OCS_SEL_RC:   ocs_pick_clock = rc;
			`OCS_SEL_XTAL: ocs_pick_clock = xtal;
			default:       ocs_pick_clock = pin;
		endcase
	endfunction

	// ============================================================
	// state
	ocs_state_type state;
	ocs_state_type next_state;
	logic [1:0]    extSel;
	logic [1:0]    next_extSel;
	logic          next_quad;
	logic          next_double;
	logic          next_ecg;
	logic          next_engaged;
	logic          next_intRun;
	logic          next_extRun;
	logic [`OCS_TRIM_WIDTH-1:0] next_trim;
	logic          next_clkInIsClock;
	ocs_pin_type   next_pin;
	logic          next_portIn;
	logic          rawExtClock;
	logic          extLevel;
	logic          edgesSeen;
	logic          useExt;

	// ============================================================
	// external activity check

	// latched select keeps the synchroniser input steady during the check
	assign rawExtClock = ocs_pick_clock(extSel, clockInputPin, rcSourceClock, crystalClock);

	ocs_edge_check u_edge (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.arm     (state == ST_CHECK),
		.clkIn   (rawExtClock),
		.level   (extLevel),
		.seen    (edgesSeen)
	);

	// ============================================================
	// handover sequencer and software bits
	always_comb begin
		next_state  = state;
		next_extSel = extSel;
		next_ecg    = extClockGenEnable;
		next_trim   = intFreqTrim;
		if (ctrlWrite) begin
			next_ecg = ctrlWriteEnable;
		end
		if (trimWrite) begin
			next_trim = trimWriteData;
		end
		case (state)
			ST_INT: begin
				// an enable with the internal source selected is simply ignored
				if (extClockGenEnable && cfg.srcSel != `OCS_SEL_INT) begin
					next_state  = ST_CHECK;
					next_extSel = cfg.srcSel;
				end
			end
			ST_CHECK: begin
				if (!extClockGenEnable) begin
					next_state = ST_INT;
				end else if (edgesSeen) begin
					next_state = ST_ALIGN;
				end
			end
			ST_ALIGN: begin
				// both clocks low: no partial high phase can reach the output
				if (!extClockGenEnable) begin
					next_state = ST_INT;
				end else if (!quadRateClock && !extLevel) begin
					next_state = ST_ENGAGE;
				end
			end
			ST_ENGAGE: begin
				next_state = ST_EXT;
			end
			ST_EXT: begin
				// final: no clock monitor, a dead source is not noticed
				next_state = ST_EXT;
			end
			default: begin
				next_state = ST_INT;
			end
		endcase
		next_engaged = (next_state == ST_ENGAGE) || (next_state == ST_EXT);
	end

	// ============================================================
	// clock generation and oscillator enables
	always_comb begin
		useExt = (next_state == ST_ENGAGE) || (next_state == ST_EXT);
		// wait and break have no input here, so clocks keep running in them
		if (!oscillatorRunEnable) begin
			next_quad = 1'b0;
		end else if (useExt) begin
			next_quad = extLevel;
		end else begin
			next_quad = intSourceClock;
		end
		// halve on each quad rising edge; holds when the quad clock stops
		if (next_quad && !quadRateClock) begin
			next_double = ~doubleRateClock;
		end else begin
			next_double = doubleRateClock;
		end
		// internal cell stops one cycle after the engaged flag rises
		next_intRun = oscillatorRunEnable && (state != ST_ENGAGE) && (state != ST_EXT);
		next_extRun = oscillatorRunEnable && ocs_has_cell(cfg.srcSel);
	end

	// ============================================================
	// pin function mux
	always_comb begin
		next_clkInIsClock = cfg.srcSel != `OCS_SEL_INT;
		next_portIn       = secondPinIn;
		case (cfg.srcSel)
			`OCS_SEL_XTAL: begin
				// inverting amplifier output on the second pin
				next_pin.out = ~clockInputPin;
				next_pin.oe  = 1'b1;
			end
			`OCS_SEL_EXT: begin
				next_pin = portABit4;
			end
			default: begin
				if (cfg.pinOutEn) begin
					next_pin.out = next_quad;
					next_pin.oe  = 1'b1;
				end else begin
					next_pin = portABit4;
				end
			end
		endcase
	end

	// ============================================================
	// registers only
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state             <= ST_INT;
			extSel            <= `OCS_SEL_INT;
			quadRateClock     <= 1'b0;
			doubleRateClock   <= 1'b0;
			extClockGenEnable <= 1'b0;
			extClockEngaged   <= 1'b0;
			intOscRun         <= 1'b1;
			extOscRun         <= 1'b0;
			intFreqTrim       <= `OCS_TRIM_RESET;
			clockInputIsClock <= 1'b0;
			secondPinOut      <= 1'b0;
			secondPinOe       <= 1'b0;
			portABit4In       <= 1'b0;
		end else begin
			state             <= next_state;
			extSel            <= next_extSel;
			quadRateClock     <= next_quad;
			doubleRateClock   <= next_double;
			extClockGenEnable <= next_ecg;
			extClockEngaged   <= next_engaged;
			intOscRun         <= next_intRun;
			extOscRun         <= next_extRun;
			intFreqTrim       <= next_trim;
			clockInputIsClock <= next_clkInIsClock;
			secondPinOut      <= next_pin.out;
			secondPinOe       <= next_pin.oe;
			portABit4In       <= next_portIn;
		end
	end

	// ============================================================
	// checks

	ecg_reset_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(rst_n) |-> !extClockGenEnable)
		else $error("generator enable not cleared by reset");

	int_before_switch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state == ST_INT) && oscillatorRunEnable |=> quadRateClock == $past(intSourceClock))
		else $error("quad clock not following internal source before switch");

	engaged_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		extClockEngaged |=> extClockEngaged && !intOscRun)
		else $error("internal oscillator reselected after switch");

	int_stop_order_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!extClockEngaged && $past(rst_n) |-> intOscRun == $past(oscillatorRunEnable))
		else $error("internal oscillator stopped before engaged status");

	switch_after_edges_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state == ST_CHECK) ##1 (state == ST_ALIGN) |-> $past(edgesSeen))
		else $error("switch began without two external edges");

	no_runt_switch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(extClockEngaged) |-> !$past(quadRateClock) && !quadRateClock)
		else $error("handover not made with quad clock low");

	ext_follows_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state == ST_EXT) && oscillatorRunEnable |=> quadRateClock == $past(extLevel))
		else $error("quad clock not following external clock");

	stop_halts_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!oscillatorRunEnable |=> !quadRateClock ##0 $stable(doubleRateClock))
		else $error("clocks still running with oscillator disabled");

	double_half_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(quadRateClock) |-> doubleRateClock != $past(doubleRateClock))
		else $error("double rate clock missed a quad rising edge");

	ext_pin_port_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cfg.srcSel == `OCS_SEL_EXT |=> secondPinOe == $past(portABit4.oe)
			&& secondPinOut == $past(portABit4.out))
		else $error("second pin not given to port bit in external mode");

	clock_pin_dir_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cfg.srcSel == `OCS_SEL_XTAL |=> clockInputIsClock && secondPinOe)
		else $error("crystal mode pins not configured");

	// ============================================================
	// sequencer entry and abort

	int_select_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state == ST_INT) && (cfg.srcSel == `OCS_SEL_INT) |=> state == ST_INT)
		else $error("handover started with internal source selected");

	abort_to_int_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		((state == ST_CHECK) || (state == ST_ALIGN)) && !extClockGenEnable |=> state == ST_INT)
		else $error("cleared enable did not abort the activity check");

	// ============================================================
	// software bits

	ecg_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ctrlWrite |=> extClockGenEnable == $past(ctrlWriteEnable))
		else $error("generator enable write not taken");

	trim_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		trimWrite |=> intFreqTrim == $past(trimWriteData))
		else $error("trim write not taken");

	// ============================================================
	// pins and oscillator cells

	clk_input_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cfg.srcSel != `OCS_SEL_INT |=> clockInputIsClock)
		else $error("clock input pin not turned to clock for external source");

	xtal_pin_inv_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cfg.srcSel == `OCS_SEL_XTAL |=> secondPinOut == !$past(clockInputPin))
		else $error("second pin not inverting the clock input in crystal mode");

	pin_quad_out_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!cfg.srcSel[0] && cfg.pinOutEn |=> secondPinOe && (secondPinOut == quadRateClock))
		else $error("second pin not giving quad clock with output enable set");

	port_read_copy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=> portABit4In == $past(secondPinIn))
		else $error("port bit read path not following the pin");

	cell_run_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		oscillatorRunEnable && cfg.srcSel[1] |=> extOscRun)
		else $error("selected oscillator cell not running");

	stop_cells_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!oscillatorRunEnable |=> !extOscRun && !intOscRun)
		else $error("oscillator cell still running in stop mode");

endmodule // ocs_source_switch

// ==== bench/ocs_far_model.sv ====
// far side model: external clock source and the system integration module run enable
// assumes clk_sys is the bench clock; all changes are made on its falling edge
`timescale 1ns/1ps

module ocs_far_model (
	// clock
	input  wire logic       clk_sys,
	// scenario controls
	input  wire logic       extRun,
	input  wire logic [3:0] halfCycles,
	input  wire logic       stopReq,
	// far side outputs
	output logic            extClk,
	output logic            oscillatorRunEnable
);
	// ============================================================
	// external source
	logic [3:0] phase;

	initial begin
		extClk = 1'b0;
		phase = 4'h0;
	end

	// a stopped source stands low, it never keeps toggling on its own
	always @(negedge clk_sys) begin
		if (!extRun) begin
			extClk <= 1'b0;
			phase <= 4'h0;
		end else if (phase + 4'h1 >= halfCycles) begin
			extClk <= ~extClk;
			phase <= 4'h0;
		end else begin
			phase <= phase + 4'h1;
		end
	end

	// ============================================================
	// run enable drops only while stop mode is requested
	assign oscillatorRunEnable = ~stopReq;
endmodule // ocs_far_model

// ==== bench/testbench.sv ====
// self-checking bench of the clock source select and switch block
// assumes ocs_pkg is compiled first and ocs_defs.svh is on the include path
`timescale 1ns/1ps
`include "ocs_defs.svh"

module testbench
	import ocs_pkg::*;
;
	// ============================================================
	// signals
	logic clk_sys = 1'b0;
	logic rst_n, ctrlWrite, ctrlWriteEnable, trimWrite, intSourceClock, extRun, stopReq;
	logic cinLevel, intFree, intPh, glitchWatch, lastQuad, lastDbl, lastExt, dblSave, xtalOn;
	logic [7:0] trimWriteData, intFreqTrim;
	logic [3:0] halfCycles;
	ocs_cfg_type cfg;
	ocs_pin_type portABit4;
	wire logic extClk, oscillatorRunEnable, clockInputPin, secondPinIn;
	logic quadRateClock, doubleRateClock, extClockGenEnable, extClockEngaged, intOscRun;
	logic extOscRun, clockInputIsClock, secondPinOut, secondPinOe, portABit4In;
	int errors = 0, numChecks = 0, quadRises, dblToggles, extRises, glitches, runLen;

	typedef struct {
		logic [1:0] sel;
		logic en, pOut, pOe, cin, eOut, eOe, eClk;
	} ocs_row_type;
	// second pin function per mode; internal clock held high so quad reads 1
	ocs_row_type rows [7] = '{'{2'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0},
		'{2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0},
		'{2'h1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1},
		'{2'h2, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1},
		'{2'h2, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1},
		'{2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1},
		'{2'h3, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1}};

	// external pin carries the source while it runs; port pin has a pull-up
	assign clockInputPin = extRun ? extClk : cinLevel;
	assign secondPinIn = secondPinOe ? secondPinOut : 1'b1;

	// ============================================================
	// instances
	ocs_source_switch i_ocs_source_switch (.clk_sys(clk_sys), .rst_n(rst_n), .cfg(cfg),
		.ctrlWrite(ctrlWrite), .ctrlWriteEnable(ctrlWriteEnable), .trimWrite(trimWrite),
		.trimWriteData(trimWriteData), .intSourceClock(intSourceClock),
		.rcSourceClock(extClk & ~xtalOn), .crystalClock(extClk & xtalOn),
		.clockInputPin(clockInputPin),
		.oscillatorRunEnable(oscillatorRunEnable), .portABit4(portABit4),
		.secondPinIn(secondPinIn), .quadRateClock(quadRateClock),
		.doubleRateClock(doubleRateClock), .extClockGenEnable(extClockGenEnable),
		.extClockEngaged(extClockEngaged), .intOscRun(intOscRun), .extOscRun(extOscRun),
		.intFreqTrim(intFreqTrim), .clockInputIsClock(clockInputIsClock),
		.secondPinOut(secondPinOut), .secondPinOe(secondPinOe), .portABit4In(portABit4In));

	ocs_far_model i_ocs_far_model (.clk_sys(clk_sys), .extRun(extRun),
		.halfCycles(halfCycles), .stopReq(stopReq), .extClk(extClk),
		.oscillatorRunEnable(oscillatorRunEnable));

	// ============================================================
	// clock, internal oscillator and monitors
	always #25 clk_sys = ~clk_sys;

	// internal oscillator halts once the block stops it
	always @(negedge clk_sys) begin
		intPh <= ~intPh;
		if (!intFree)
			intSourceClock <= 1'b1;
		else if (intOscRun && intPh)
			intSourceClock <= ~intSourceClock;
	end

	// edge counts and run lengths; a one-cycle run of quad counts as a runt
	always @(posedge clk_sys) begin
		lastQuad <= quadRateClock;
		lastDbl <= doubleRateClock;
		lastExt <= clockInputPin;
		if (quadRateClock && !lastQuad)
			quadRises++;
		if (doubleRateClock !== lastDbl)
			dblToggles++;
		if (clockInputPin && !lastExt)
			extRises++;
		if (quadRateClock === lastQuad)
			runLen++;
		else begin
			if (glitchWatch && runLen < 2)
				glitches++;
			runLen = 1;
		end
	end

	// ============================================================
	// tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		numChecks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// counts may differ by one because of synchroniser lag at the window edges
	function automatic logic [7:0] near(input int a, input int b);
		return 8'(a <= b + 1 && b <= a + 1);
	endfunction

	task automatic clear_counts();
		quadRises = 0;
		dblToggles = 0;
		extRises = 0;
	endtask

	task automatic wr_enable(input logic v);
		ctrlWriteEnable = v;
		ctrlWrite = 1'b1;
		cyc(1);
		ctrlWrite = 1'b0;
		cyc(1);
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", numChecks, errors);
		if (errors == 0 && numChecks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ============================================================
	// watchdog, far beyond the roughly 700 cycles the sequence needs
	initial begin
		cyc(4000);
		errors++;
		end_sim();
	end

	// ============================================================
	// main sequence
	initial begin
		rst_n = 1'b0;
		cfg = '0;
		{ctrlWrite, ctrlWriteEnable, trimWrite, extRun, stopReq, cinLevel} = '0;
		{intFree, intPh, glitchWatch, intSourceClock, xtalOn} = '0;
		trimWriteData = 8'h00;
		halfCycles = 4'h4;
		portABit4 = '0;
		clear_counts();
		glitches = 0;
		runLen = 0;
		cyc(6);
		check(8'(intOscRun), 8'h01);
		check(8'(extClockGenEnable), 8'h00);
		check(8'(extClockEngaged), 8'h00);
		check(intFreqTrim, `OCS_TRIM_RESET);
		rst_n = 1'b1;
		for (int i = 0; i < 7; i++) begin
			cfg.srcSel = rows[i].sel;
			cfg.pinOutEn = rows[i].en;
			portABit4 = '{rows[i].pOut, rows[i].pOe};
			cinLevel = rows[i].cin;
			cyc(4);
			check(8'(secondPinOut), 8'(rows[i].eOut));
			check(8'(secondPinOe), 8'(rows[i].eOe));
			check(8'(clockInputIsClock), 8'(rows[i].eClk));
			check(8'(extOscRun), 8'(rows[i].sel[1]));
			check(8'(portABit4In), 8'(rows[i].eOe ? rows[i].eOut : 1'b1));
		end
		// trim write and free-running internal clock
		cfg = '0;
		portABit4 = '0;
		trimWriteData = 8'h3c;
		trimWrite = 1'b1;
		cyc(1);
		trimWrite = 1'b0;
		intFree = 1'b1;
		cyc(8);
		check(intFreqTrim, 8'h3c);
		clear_counts();
		cyc(64);
		check(near(quadRises, 16), 8'h01);
		check(near(dblToggles, quadRises), 8'h01);
		// stop mode halts both clocks; double keeps its level
		stopReq = 1'b1;
		cyc(4);
		dblSave = doubleRateClock;
		clear_counts();
		cyc(20);
		check(8'(quadRises), 8'h00);
		check(8'(intOscRun), 8'h00);
		check(8'(doubleRateClock), 8'(dblSave));
		stopReq = 1'b0;
		// enable with internal select is stored but starts nothing
		wr_enable(1'b1);
		check(8'(extClockGenEnable), 8'h01);
		cyc(40);
		check(8'(extClockEngaged), 8'h00);
		wr_enable(1'b0);
		// dead external clock never completes the activity check
		cfg.srcSel = `OCS_SEL_EXT;
		wr_enable(1'b1);
		cyc(40);
		check(8'(extClockEngaged), 8'h00);
		check(8'(intOscRun), 8'h01);
		wr_enable(1'b0);
		// slow source, settle first, then request the handover
		extRun = 1'b1;
		halfCycles = 4'h8;
		cyc(40);
		glitchWatch = 1'b1;
		clear_counts();
		wr_enable(1'b1);
		for (int i = 0; i < 300 && extClockEngaged !== 1'b1; i++)
			cyc(1);
		check(8'(extClockEngaged), 8'h01);
		check(8'(extRises >= 2), 8'h01);
		check(8'(intOscRun), 8'h01);
		cyc(1);
		check(8'(intOscRun), 8'h00);
		halfCycles = 4'h4;
		cyc(10);
		clear_counts();
		cyc(80);
		check(near(quadRises, extRises), 8'h01);
		check(near(dblToggles, quadRises), 8'h01);
		glitchWatch = 1'b0;
		check(8'(glitches), 8'h00);
		// external source dies and the enable is cleared: no way back
		extRun = 1'b0;
		wr_enable(1'b0);
		cyc(40);
		check(8'(extClockEngaged), 8'h01);
		check(8'(intOscRun), 8'h00);
		// only reset brings the internal oscillator back
		rst_n = 1'b0;
		cyc(2);
		rst_n = 1'b1;
		cyc(1);
		check(8'(extClockEngaged), 8'h00);
		check(8'(intOscRun), 8'h01);
		check(8'(extClockGenEnable), 8'h00);
		// rc then crystal handover, each after its own reset; the other source stands low
		for (int m = 0; m < 2; m++) begin
			rst_n = 1'b0;
			extRun = 1'b0;
			xtalOn = 1'(m);
			cyc(2);
			rst_n = 1'b1;
			portABit4 = '{1'b1, 1'b1};
			cyc(8);
			check(8'(secondPinOut), 8'h01);
			cfg.srcSel = m ? `OCS_SEL_XTAL : `OCS_SEL_RC;
			portABit4 = '0;
			extRun = 1'b1;
			cyc(40);
			wr_enable(1'b1);
			for (int i = 0; i < 300 && extClockEngaged !== 1'b1; i++)
				cyc(1);
			check(8'(extClockEngaged), 8'h01);
			check(8'(extOscRun), 8'h01);
			clear_counts();
			cyc(40);
			check(near(quadRises, extRises), 8'h01);
			stopReq = 1'b1;
			cyc(4);
			check(8'(quadRateClock), 8'h00);
			check(8'(extOscRun), 8'h00);
			stopReq = 1'b0;
		end
		end_sim();
	end
endmodule // testbench
